// file: rtl/hpfs_map.vh
`ifndef HPFS_MAP_VH
`define HPFS_MAP_VH
`define HPFS_NUM_PINS      11
`define HPFS_PIN_D6        0
`define HPFS_PIN_D7        1
`define HPFS_PIN_SEL0      2
`define HPFS_PIN_SEL2      4
`define HPFS_PIN_DIR       5
`define HPFS_PIN_STROBE    6
`define HPFS_PIN_CS        7
`define HPFS_PIN_REQ       8
`define HPFS_PIN_ACK       9
`define HPFS_PIN_RXREQ     9
`define HPFS_BUS_SINGLE    1'b0
`define HPFS_BUS_DOUBLE    1'b1
`define HPFS_REQMODE_ONE   1'b0
`define HPFS_REQMODE_SPLIT 1'b1
`define HPFS_PIN_IDLE      11'h000
`endif

// file: rtl/hpfs_od_out.v
`timescale 1ns/1ns
`include "hpfs_map.vh"
module hpfs_od_out (
    input  wire i_clk,
    input  wire i_rstn,
    input  wire i_host_en,
    input  wire i_assert,
    input  wire i_gpio_out,
    input  wire i_gpio_oe,
    output reg  o_pin_out,
    output reg  o_pin_oe
);
    // Host mode drives low only; otherwise a port B pin
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            o_pin_out <= 1'b0;
            o_pin_oe  <= 1'b0;
        end else if (i_host_en) begin
            o_pin_out <= 1'b0;
            o_pin_oe  <= i_assert;
        end else begin
            o_pin_out <= i_gpio_out;
            o_pin_oe  <= i_gpio_oe;
        end
    end
endmodule // hpfs_od_out

// file: rtl/hpfs_pin_select.v
`timescale 1ns/1ns
`include "hpfs_map.vh"
module hpfs_pin_select #(
    parameter NUM_PINS = `HPFS_NUM_PINS
) (
    input  wire                i_clk,
    input  wire                i_rstn,
    input  wire [NUM_PINS-1:0] i_host_pin_sel,
    input  wire                i_bus_mode,
    input  wire                i_request_mode_select,
    input  wire [NUM_PINS-1:0] i_pin_in,
    output wire [NUM_PINS-1:0] o_pin_out,
    output wire [NUM_PINS-1:0] o_pin_oe,
    input  wire [NUM_PINS-1:0] i_gpio_out,
    input  wire [NUM_PINS-1:0] i_gpio_oe,
    output reg  [NUM_PINS-1:0] o_gpio_in,
    input  wire                i_tx_request,
    input  wire                i_rx_request,
    output reg  [2:0]          o_host_reg_select,
    output reg  [1:0]          o_host_data_upper,
    output wire                o_host_read_start,
    output wire                o_host_write_start,
    output wire                o_host_busy,
    output reg                 o_host_acknowledge
);
    wire pin_sel_full;
    wire req_host;
    wire rxreq_host;
    wire req_assert;
    wire rxreq_assert;
    wire [1:0] next_data;
    wire [2:0] next_sel;
    genvar g;

    // Host strobes only usable when direction, strobe and select pins are all host
    assign pin_sel_full = i_rstn & i_host_pin_sel[`HPFS_PIN_DIR]
                        & i_host_pin_sel[`HPFS_PIN_STROBE] & i_host_pin_sel[`HPFS_PIN_CS];

    // Data and register select are forced to zero during reset or gpio use
    assign next_data = {i_host_pin_sel[`HPFS_PIN_D7] & i_pin_in[`HPFS_PIN_D7],
                        i_host_pin_sel[`HPFS_PIN_D6] & i_pin_in[`HPFS_PIN_D6]};
    assign next_sel  = i_host_pin_sel[`HPFS_PIN_SEL2:`HPFS_PIN_SEL0]
                     & i_pin_in[`HPFS_PIN_SEL2:`HPFS_PIN_SEL0];

    always @(posedge i_clk) begin
        if (!i_rstn) begin
            o_host_data_upper  <= 2'h0;
            o_host_reg_select  <= 3'h0;
            o_host_acknowledge <= 1'b0;
        end else begin
            o_host_data_upper  <= next_data;
            o_host_reg_select  <= next_sel;
            o_host_acknowledge <= i_host_pin_sel[`HPFS_PIN_ACK]
                                & (i_request_mode_select == `HPFS_REQMODE_ONE)
                                & ~i_pin_in[`HPFS_PIN_ACK];
        end
    end

    hpfs_strobe_decode u_strobe (
        .i_clk         (i_clk),
        .i_rstn        (i_rstn),
        .i_active      (pin_sel_full),
        .i_bus_mode    (i_bus_mode),
        .i_select_n    (i_pin_in[`HPFS_PIN_CS]),
        .i_dir_pin     (i_pin_in[`HPFS_PIN_DIR]),
        .i_strobe_pin  (i_pin_in[`HPFS_PIN_STROBE]),
        .o_read_start  (o_host_read_start),
        .o_write_start (o_host_write_start),
        .o_busy        (o_host_busy)
    );

    // Mode 0: one combined request; mode 1: transmit on request pin, receive on second pin
    assign req_host     = i_host_pin_sel[`HPFS_PIN_REQ];
    assign rxreq_host   = i_host_pin_sel[`HPFS_PIN_RXREQ]
                        & (i_request_mode_select == `HPFS_REQMODE_SPLIT);
    assign req_assert   = (i_request_mode_select == `HPFS_REQMODE_ONE)
                        ? (i_tx_request | i_rx_request)
                        : i_tx_request;
    assign rxreq_assert = i_rx_request;

    hpfs_od_out u_req (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_host_en  (req_host),
        .i_assert   (req_assert),
        .i_gpio_out (i_gpio_out[`HPFS_PIN_REQ]),
        .i_gpio_oe  (i_gpio_oe[`HPFS_PIN_REQ]),
        .o_pin_out  (o_pin_out[`HPFS_PIN_REQ]),
        .o_pin_oe   (o_pin_oe[`HPFS_PIN_REQ])
    );

    hpfs_od_out u_rxreq (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_host_en  (rxreq_host | i_host_pin_sel[`HPFS_PIN_ACK]),
        .i_assert   (rxreq_host & rxreq_assert),
        .i_gpio_out (i_gpio_out[`HPFS_PIN_RXREQ]),
        .i_gpio_oe  (i_gpio_oe[`HPFS_PIN_RXREQ]),
        .o_pin_out  (o_pin_out[`HPFS_PIN_RXREQ]),
        .o_pin_oe   (o_pin_oe[`HPFS_PIN_RXREQ])
    );

    // Input-only host pins fall back to port B gpio
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_gpio
            if (g != `HPFS_PIN_REQ && g != `HPFS_PIN_RXREQ) begin : g_in
                reg pin_out;
                reg pin_oe;
                always @(posedge i_clk) begin
                    if (!i_rstn) begin
                        pin_out <= 1'b0;
                        pin_oe  <= 1'b0;
                    end else begin
                        pin_out <= i_gpio_out[g] & ~i_host_pin_sel[g];
                        pin_oe  <= i_gpio_oe[g] & ~i_host_pin_sel[g];
                    end
                end
                assign o_pin_out[g] = pin_out;
                assign o_pin_oe[g]  = pin_oe;
            end
        end
    endgenerate

    always @(posedge i_clk) begin
        if (!i_rstn) begin
            o_gpio_in <= `HPFS_PIN_IDLE;
        end else begin
            o_gpio_in <= i_pin_in & ~i_host_pin_sel;
        end
    end
endmodule // hpfs_pin_select

// file: rtl/hpfs_strobe_decode.v
`timescale 1ns/1ns
`include "hpfs_map.vh"
module hpfs_strobe_decode (
    input  wire i_clk,
    input  wire i_rstn,
    input  wire i_active,
    input  wire i_bus_mode,
    input  wire i_select_n,
    input  wire i_dir_pin,
    input  wire i_strobe_pin,
    output reg  o_read_start,
    output reg  o_write_start,
    output reg  o_busy
);
    reg  strobe_prev;
    wire sel;
    wire strobe_on;
    wire is_read;
    wire next_busy;

    assign sel       = i_active & ~i_select_n;
    // Single mode: shared pin is direction, strobe is data strobe
    assign strobe_on = (i_bus_mode == `HPFS_BUS_SINGLE) ? ~i_strobe_pin
                     : (~i_strobe_pin | ~i_dir_pin);
    assign is_read   = (i_bus_mode == `HPFS_BUS_SINGLE) ? i_dir_pin
                     : ~i_dir_pin;
    assign next_busy = sel & strobe_on;

    always @(posedge i_clk) begin
        if (!i_rstn) begin
            strobe_prev   <= 1'b0;
            o_read_start  <= 1'b0;
            o_write_start <= 1'b0;
            o_busy        <= 1'b0;
        end else begin
            strobe_prev   <= next_busy;
            o_busy        <= next_busy;
            o_read_start  <= next_busy & ~strobe_prev & is_read;
            o_write_start <= next_busy & ~strobe_prev & ~is_read;
        end
    end
endmodule // hpfs_strobe_decode

// file: test/hpfs_host_model.sv
`timescale 1ns/1ns
module hpfs_host_model (
    input  wire       i_clk,
    input  wire [1:0] i_req_oe,
    input  wire [1:0] i_req_out,
    output wire [9:0] o_pin
);
    reg       cs_n = 1'b1;
    reg       rd   = 1'b1;
    reg       ds   = 1'b1;
    reg       ack  = 1'b1;
    reg [4:0] ad   = 5'h1f;
    // Released request pin floats to the pull-up level; released pin 9 reads the host ack level
    assign o_pin = {i_req_oe[1] ? i_req_out[1] : ack, i_req_oe[0] ? i_req_out[0] : 1'b1,
                    cs_n, ds, rd, ad};
    task xfer(input dbl, input wr, input sel_n, input [4:0] v);
        begin
            @(posedge i_clk);
            cs_n <= sel_n;
            ad <= v;
            rd <= dbl ? wr : !wr;
            ds <= dbl & !wr;
            repeat (4) @(posedge i_clk);
            cs_n <= 1'b1;
            rd <= 1'b1;
            ds <= 1'b1;
            ad <= ~v;
            repeat (2) @(posedge i_clk);
        end
    endtask
endmodule // hpfs_host_model

// file: test/hpfs_pin_select_monitor.sv
`timescale 1ns/1ns
module hpfs_pin_select_monitor #(parameter NUM_PINS = 11) (
    input wire i_clk, input wire i_rstn, input wire i_bus_mode, input wire i_request_mode_select,
    input wire [NUM_PINS-1:0] i_host_pin_sel, input wire [NUM_PINS-1:0] i_pin_in,
    input wire [NUM_PINS-1:0] o_pin_out, input wire [NUM_PINS-1:0] o_pin_oe,
    input wire [NUM_PINS-1:0] o_gpio_in, input wire i_tx_request, input wire i_rx_request,
    input wire [2:0] o_host_reg_select, input wire [1:0] o_host_data_upper,
    input wire o_host_read_start, input wire o_host_write_start
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    a_reg_select: assert property ($past(i_rstn) |-> o_host_reg_select ==
        ($past(i_pin_in[4:2]) & $past(i_host_pin_sel[4:2]))) else $error("select wrong");
    a_data_upper: assert property ($past(i_rstn) |-> o_host_data_upper ==
        ($past(i_pin_in[1:0]) & $past(i_host_pin_sel[1:0]))) else $error("data wrong");
    a_reset_cut: assert property (!$past(i_rstn) |->
        o_host_reg_select == 3'h0 && o_host_data_upper == 2'h0) else $error("reset leak");
    a_gpio_in: assert property ($past(i_rstn) |-> o_gpio_in ==
        ($past(i_pin_in) & ~$past(i_host_pin_sel))) else $error("gpio in wrong");
    a_read_cause: assert property (o_host_read_start |-> &$past(i_host_pin_sel[7:5]) &&
        !$past(i_pin_in[7]) && ($past(i_bus_mode) ? !$past(i_pin_in[5]) :
        !$past(i_pin_in[6]) && $past(i_pin_in[5]))) else $error("bad read start");
    a_write_cause: assert property (o_host_write_start |-> &$past(i_host_pin_sel[7:5]) &&
        !$past(i_pin_in[7]) && !$past(i_pin_in[6]) && ($past(i_bus_mode) == $past(i_pin_in[5])))
        else $error("bad write start");
    a_req_mode: assert property ($past(i_rstn) && $past(i_host_pin_sel[8]) |-> o_pin_oe[8] ==
        ($past(i_tx_request) | $past(i_rx_request) & !$past(i_request_mode_select)))
        else $error("request wrong");
    a_rxreq_mode: assert property ($past(i_rstn) && $past(i_host_pin_sel[9]) |->
        o_pin_oe[9] == ($past(i_rx_request) & $past(i_request_mode_select)))
        else $error("receive request wrong");
    a_od_low: assert property ($past(i_host_pin_sel[8]) && o_pin_oe[8] |-> !o_pin_out[8])
        else $error("request driven high");
endmodule // hpfs_pin_select_monitor

// file: test/hpfs_pin_select_test.sv
`timescale 1ns/1ns
module hpfs_pin_select_test;
    reg  i_clk = 1'b0, i_rstn = 1'b0, bm = 1'b0, rm = 1'b0, tx = 1'b0, rx = 1'b0;
    reg  [10:0] sel = 11'h3ff, ext = 11'h000, g_out = 11'h000, g_oe = 11'h000;
    reg  [4:0] v;
    wire [10:0] p_out, p_oe, g_in;
    wire [9:0] hp;
    wire [2:0] rs;
    wire [1:0] du;
    wire rd_go, wr_go, ackd, busy;
    wire [10:0] pins = (sel & {1'b0, hp}) | (~sel & ext);
    integer num_errors = 0, compares = 0, seed = 32'h21145292, cyc = 0, n_rd = 0, n_wr = 0, i, c;
    integer n_bz = 0, b;
    hpfs_pin_select #(.NUM_PINS(11)) u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_host_pin_sel(sel),
        .i_bus_mode(bm), .i_request_mode_select(rm), .i_pin_in(pins), .o_pin_out(p_out),
        .o_pin_oe(p_oe), .i_gpio_out(g_out), .i_gpio_oe(g_oe), .o_gpio_in(g_in),
        .i_tx_request(tx), .i_rx_request(rx), .o_host_reg_select(rs), .o_host_data_upper(du),
        .o_host_read_start(rd_go), .o_host_write_start(wr_go), .o_host_busy(busy),
        .o_host_acknowledge(ackd));
    hpfs_host_model u_host (.i_clk(i_clk), .i_req_oe(p_oe[9:8]), .i_req_out(p_out[9:8]), .o_pin(hp));
    always #25 i_clk = ~i_clk;
    function [10:0] exp_req(input m, input t, input r);
        exp_req = {9'h000, !(m & r), !(m ? t : t | r)};
    endfunction
    task chk(input [10:0] got, input [10:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("errors=%0d compares=%0d", num_errors, compares);
            if (num_errors == 0 && compares > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task settle;
        begin
            repeat (2) @(posedge i_clk);
            @(negedge i_clk);
        end
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        n_rd <= n_rd + rd_go;
        n_wr <= n_wr + wr_go;
        n_bz <= n_bz + busy;
        if (cyc == 3000) begin
            num_errors = num_errors + 1;
            close_out;
        end
    end
    initial begin
        repeat (16) @(posedge i_clk) ext <= $random(seed);
        @(negedge i_clk) chk({6'h00, du, rs}, 11'h000);
        @(posedge i_clk) i_rstn <= 1'b1;
        for (i = 0; i < 12; i = i + 1) begin
            bm <= i[0];
            sel <= (i > 7) ? 11'h3bf : 11'h3ff;
            v = $random(seed);
            c = n_rd + 2 * n_wr;
            b = n_bz;
            u_host.xfer(i[0], i[1], i[2], v);
            c = n_rd + 2 * n_wr - c;
            b = n_bz - b;
            chk(c[10:0], {9'h000, i < 4 && i[1], i < 4 && !i[1]});
            chk(b[10:0], (i < 4) ? 11'h004 : 11'h000);
            chk({6'h00, du, rs}, {6'h00, ~v[1:0], ~v[4:2]});
        end
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge i_clk) {rm, tx, rx} <= i[2:0];
            settle;
            chk({9'h000, hp[9:8]}, exp_req(i[2], i[1], i[0]));
            chk({10'h000, ackd}, 11'h000);
        end
        @(posedge i_clk) {rm, tx, rx, u_host.ack} <= 4'h0;
        settle;
        chk({10'h000, ackd}, 11'h001);
        for (i = 0; i < 20; i = i + 1) begin
            @(posedge i_clk) sel <= $random(seed) & 11'h3ff;
            {ext, g_out, g_oe} <= {$random(seed), $random(seed)};
            settle;
            chk(g_in, ext & ~sel);
            chk(p_oe & ~sel, g_oe & ~sel);
            chk(p_out & ~sel, g_out & ~sel);
        end
        close_out;
    end
endmodule // hpfs_pin_select_test
bind hpfs_pin_select hpfs_pin_select_monitor #(.NUM_PINS(NUM_PINS)) u_mon (.*);
